/* mise_core_model.sv */
// model of the core as sfr bus master: one strobe cycle per write or read
module mise_core_model
  import mise_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // sfr bus toward the block
  output logic [7:0] sfr_addr_o,
  output logic sfr_wr_o,
  output logic [7:0] sfr_wdata_o,
  output logic sfr_rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sfr_addr_o = 8'hFF;
    sfr_wr_o = 1'b0;
    sfr_wdata_o = 8'hFF;
    sfr_rd_o = 1'b0;
  end
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    // software never sets the reserved calibration bits
    d = (addr == MISE_ADDR_CAL) ? (data & MISE_CAL_MASK) : data;
    @(negedge ref_clk_i);
    sfr_addr_o = addr;
    sfr_wdata_o = d;
    sfr_wr_o = 1'b1;
    @(negedge ref_clk_i);
    sfr_wr_o = 1'b0;
    // released lines show the inverse so a stale value cannot pass
    sfr_addr_o = ~addr;
    sfr_wdata_o = ~d;
  endtask
  task automatic read(input logic [7:0] addr);
    @(negedge ref_clk_i);
    sfr_addr_o = addr;
    sfr_rd_o = 1'b1;
    @(negedge ref_clk_i);
    sfr_rd_o = 1'b0;
    sfr_addr_o = ~addr;
  endtask
endmodule

/* mise_pkg.sv */
// register map, field layout and event carriers of the metering interrupt status/enable block
package mise_pkg;
  localparam logic [7:0] MISE_ADDR_CAL = 8'h3D;
  localparam logic [7:0] MISE_ADDR_EN_LOW = 8'hD9;
  localparam logic [7:0] MISE_ADDR_EN_MID = 8'hDA;
  localparam logic [7:0] MISE_ADDR_EN_HIGH = 8'hDB;
  localparam logic [7:0] MISE_ADDR_ST_LOW = 8'hDC;
  localparam logic [7:0] MISE_ADDR_ST_MID = 8'hDD;
  localparam logic [7:0] MISE_ADDR_ST_HIGH = 8'hDE;
  localparam logic [7:0] MISE_RST_BYTE = 8'h00;
  localparam logic [7:0] MISE_CAL_MASK = 8'h3C;
  localparam logic [7:0] MISE_EN_LOW_MASK = 8'h3F;
  localparam logic [7:0] MISE_ST_LOW_MASK = 8'h3F;
  localparam logic [7:0] MISE_ST_HIGH_MASK = 8'hBF;
  localparam int MISE_CAL_SEL_LSB = 4;
  localparam int MISE_CAL_IGND_BIT = 2;
  localparam int MISE_CAL_VGND_BIT = 3;
  localparam int MISE_SUMMARY_BIT = 7;
  localparam int MISE_RESET_DONE_BIT = 7;
  localparam int MISE_PULSE_TWO_BIT = 7;
  localparam logic [1:0] MISE_SEL_FORCE_A = 2'h1;
  localparam logic [1:0] MISE_SEL_FORCE_B = 2'h2;

  // one-cycle event pulses from the metering datapath
  typedef struct packed {
    logic apparent_noload;
    logic rms_noload_entry;
    logic reactive_noload;
    logic active_noload;
    logic pulse_out_two;
    logic pulse_out_one;
    logic [2:0] overflow;
    logic [2:0] halffull;
    logic soft_reset_done;
    logic waveform_ready;
    logic current_peak;
    logic voltage_peak;
    logic cycle_done;
    logic crossing_timeout;
    logic crossing;
  } mise_evt_t;

  // levels whose transitions raise the sign/fault flags
  typedef struct packed {
    logic fault_mode;
    logic reactive_neg;
    logic active_neg;
  } mise_sign_t;
endpackage

/* mise_sign_edge.sv */
// transition detector with selectable direction for the sign and fault flags
module mise_sign_edge
  import mise_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // level and chosen direction
  input wire logic level_i,
  input wire logic dir_i,
  // detected change
  output logic change_o
);
  logic prev_reg;
  logic primed_reg;

  // the first cycle after reset only samples: an unknown history must not look like a change
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_reg <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      prev_reg <= level_i;
      primed_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      change_o <= 1'b0;
    end else begin
      change_o <= primed_reg && (dir_i ? (prev_reg && !level_i) : (!prev_reg && level_i)); // RQ22
    end
  end

  property p_dir_rise;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (primed_reg && !dir_i && !prev_reg && level_i) |=> change_o;
  endproperty
  a_dir_rise: assert property (p_dir_rise) else $error("rising change not reported"); // RQ22

  property p_dir_fall;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (primed_reg && dir_i && !level_i && !prev_reg) |=> !change_o;
  endproperty
  a_dir_fall: assert property (p_dir_fall) else $error("change reported without transition"); // RQ22
endmodule

/* mise_top.sv */
// metering interrupt status/enable registers and calibration mode register on the core's sfr bus
// Summary of operation
// [RQ1] select bits 5:4 choose current input: 01 A, 10 B, else tamper choice
// [RQ2] calibration bit 2 grounds the current channel input
// [RQ3] calibration bit 3 grounds the voltage channel input
// [RQ4] software keeps calibration bits 7:6 and 1:0 at zero
// [RQ5] summary bit 7 of low status set when any enabled flag is set
// [RQ6] summary bit clears itself once all enabled flags are cleared
// [RQ7] low status bit 5 set on fault mode change in configured direction
// [RQ8] low status bit 4 set on reactive sign change in configured direction
// [RQ9] low status bit 3 set on active sign change in configured direction
// [RQ10] low status bit 2 set on apparent no-load or rms no-load entry
// [RQ11] low status bits 1 and 0 set on reactive and active no-load
// [RQ12] mid status bits 7 and 6 set on each pulse, pin enabled or not
// [RQ13] mid status bits 5:3 set on apparent, reactive, active accumulator overflow
// [RQ14] mid status bits 2:0 set on apparent, reactive, active half-full
// [RQ15] high status bit 7 set when a hardware or software reset completes
// [RQ16] high status bit 5 set when new waveform sample is stored
// [RQ17] high status bit 4 on current peak, bit 3 on voltage peak
// [RQ18] high status bit 2 set at end of accumulation over half cycles
// [RQ19] high status bit 1 set on zero-crossing timeout
// [RQ20] high status bit 0 set on each voltage zero crossing
// [RQ21] low enable bits 5:0 let matching low flags raise the interrupt
// [RQ22] direction bits: fault 0 entering fault; sign 0 positive-to-negative
// [RQ23] mid and high enable registers gate mid and high flags bit for bit
// [RQ24] flags stay set until software clears them, each independently
module mise_top
  import mise_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // sfr bus of the core
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  // metering events and levels
  input wire mise_evt_t evt_i,
  input wire mise_sign_t sign_i,
  input wire mise_sign_t sign_dir_i,
  input wire logic tamper_sel_b_i,
  // analog front-end control
  output logic meas_use_b_o,
  output logic current_input_ground_o,
  output logic voltage_input_ground_o,
  // interrupt to the core
  output logic metering_irq_o
);
  logic [7:0] calibration_mode_reg;
  logic [7:0] irq_enable_low_reg;
  logic [7:0] irq_enable_mid_reg;
  logic [7:0] irq_enable_high_reg;
  logic [7:0] irq_status_low_reg;
  logic [7:0] irq_status_mid_reg;
  logic [7:0] irq_status_high_reg;
  logic rst_seen_reg;
  logic fault_chg;
  logic react_chg;
  logic act_chg;
  logic [7:0] set_low;
  logic [7:0] set_mid;
  logic [7:0] set_high;
  logic pending_next;

  // write-zero-to-clear keeps bit writes from the core safe for other flags; set beats clear
  function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] set,
                                           input logic hit, input logic [7:0] wdata,
                                           input logic [7:0] mask);
    logic [7:0] clr;
    clr = hit ? ~wdata : 8'h00;
    flag_next = ((cur & ~clr) | set) & mask;
  endfunction

  function automatic logic wr_hit(input logic [7:0] addr, input logic wr, input logic [7:0] target);
    wr_hit = wr && (addr == target);
  endfunction

  mise_sign_edge u_fault_edge (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .level_i(sign_i.fault_mode),
    .dir_i(sign_dir_i.fault_mode),
    .change_o(fault_chg)
  );

  mise_sign_edge u_react_edge (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .level_i(sign_i.reactive_neg),
    .dir_i(sign_dir_i.reactive_neg),
    .change_o(react_chg)
  );

  mise_sign_edge u_act_edge (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .level_i(sign_i.active_neg),
    .dir_i(sign_dir_i.active_neg),
    .change_o(act_chg)
  );

  always_comb begin
    set_low = {2'h0, fault_chg, react_chg, act_chg, // RQ7 RQ8 RQ9
               evt_i.apparent_noload | evt_i.rms_noload_entry, // RQ10
               evt_i.reactive_noload, evt_i.active_noload}; // RQ11
    set_mid = {evt_i.pulse_out_two, evt_i.pulse_out_one, // RQ12
               evt_i.overflow, // RQ13
               evt_i.halffull}; // RQ14
    set_high = {(!rst_seen_reg) | evt_i.soft_reset_done, 1'b0, // RQ15
                evt_i.waveform_ready, // RQ16
                evt_i.current_peak, evt_i.voltage_peak, // RQ17
                evt_i.cycle_done, // RQ18
                evt_i.crossing_timeout, // RQ19
                evt_i.crossing}; // RQ20
  end

  // marks the first clock after reset release so the reset-done flag is set once
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_seen_reg <= 1'b0;
    end else begin
      rst_seen_reg <= 1'b1;
    end
  end

  // calibration mode; reserved bits are not stored, so they read back as zero
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      calibration_mode_reg <= MISE_RST_BYTE;
    end else if (wr_hit(sfr_addr_i, sfr_wr_i, MISE_ADDR_CAL)) begin
      calibration_mode_reg <= sfr_wdata_i & MISE_CAL_MASK; // RQ4
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_enable_low_reg <= MISE_RST_BYTE;
      irq_enable_mid_reg <= MISE_RST_BYTE;
      irq_enable_high_reg <= MISE_RST_BYTE;
    end else begin
      if (wr_hit(sfr_addr_i, sfr_wr_i, MISE_ADDR_EN_LOW)) begin
        irq_enable_low_reg <= sfr_wdata_i & MISE_EN_LOW_MASK;
      end
      if (wr_hit(sfr_addr_i, sfr_wr_i, MISE_ADDR_EN_MID)) begin
        irq_enable_mid_reg <= sfr_wdata_i;
      end
      if (wr_hit(sfr_addr_i, sfr_wr_i, MISE_ADDR_EN_HIGH)) begin
        irq_enable_high_reg <= sfr_wdata_i & MISE_ST_HIGH_MASK;
      end
    end
  end

  // sticky flags, each cleared only by its own zero bit in a write
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_status_low_reg <= MISE_RST_BYTE;
      irq_status_mid_reg <= MISE_RST_BYTE;
      irq_status_high_reg <= MISE_RST_BYTE;
    end else begin
      irq_status_low_reg <= flag_next(irq_status_low_reg, set_low, // RQ24
        wr_hit(sfr_addr_i, sfr_wr_i, MISE_ADDR_ST_LOW), sfr_wdata_i, MISE_ST_LOW_MASK);
      irq_status_mid_reg <= flag_next(irq_status_mid_reg, set_mid, // RQ24
        wr_hit(sfr_addr_i, sfr_wr_i, MISE_ADDR_ST_MID), sfr_wdata_i, 8'hFF);
      irq_status_high_reg <= flag_next(irq_status_high_reg, set_high, // RQ24
        wr_hit(sfr_addr_i, sfr_wr_i, MISE_ADDR_ST_HIGH), sfr_wdata_i, MISE_ST_HIGH_MASK);
    end
  end

  assign pending_next = |(irq_status_low_reg & irq_enable_low_reg) // RQ21
                      | |(irq_status_mid_reg & irq_enable_mid_reg) // RQ23
                      | |(irq_status_high_reg & irq_enable_high_reg); // RQ23

  // summary follows the gated flags one cycle late, setting and clearing by itself
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      metering_irq_o <= 1'b0;
    end else begin
      metering_irq_o <= pending_next; // RQ5 RQ6
    end
  end

  // front-end routing follows the stored calibration bits one cycle later
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meas_use_b_o <= 1'b0;
      current_input_ground_o <= 1'b0;
      voltage_input_ground_o <= 1'b0;
    end else begin
      unique case (calibration_mode_reg[MISE_CAL_SEL_LSB +: 2])
        MISE_SEL_FORCE_A: meas_use_b_o <= 1'b0; // RQ1
        MISE_SEL_FORCE_B: meas_use_b_o <= 1'b1; // RQ1
        default: meas_use_b_o <= tamper_sel_b_i; // RQ1
      endcase
      current_input_ground_o <= calibration_mode_reg[MISE_CAL_IGND_BIT]; // RQ2
      voltage_input_ground_o <= calibration_mode_reg[MISE_CAL_VGND_BIT]; // RQ3
    end
  end

  // read data registered; unmapped addresses answer zero
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= MISE_RST_BYTE;
    end else if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        MISE_ADDR_CAL: sfr_rdata_o <= calibration_mode_reg;
        MISE_ADDR_EN_LOW: sfr_rdata_o <= irq_enable_low_reg;
        MISE_ADDR_EN_MID: sfr_rdata_o <= irq_enable_mid_reg;
        MISE_ADDR_EN_HIGH: sfr_rdata_o <= irq_enable_high_reg;
        MISE_ADDR_ST_LOW: sfr_rdata_o <= {metering_irq_o, irq_status_low_reg[6:0]}; // RQ5
        MISE_ADDR_ST_MID: sfr_rdata_o <= irq_status_mid_reg;
        MISE_ADDR_ST_HIGH: sfr_rdata_o <= irq_status_high_reg;
        default: sfr_rdata_o <= MISE_RST_BYTE;
      endcase
    end
  end

  property p_sel_force_a;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (calibration_mode_reg[MISE_CAL_SEL_LSB +: 2] == MISE_SEL_FORCE_A) |=> !meas_use_b_o;
  endproperty
  a_sel_force_a: assert property (p_sel_force_a) else $error("forced input A not routed"); // RQ1

  property p_cur_ground;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (sfr_wr_i && sfr_addr_i == MISE_ADDR_CAL) |=> ##1
        (current_input_ground_o == $past(sfr_wdata_i[MISE_CAL_IGND_BIT], 2));
  endproperty
  a_cur_ground: assert property (p_cur_ground) else $error("current ground does not follow write"); // RQ2

  property p_volt_ground;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (sfr_wr_i && sfr_addr_i == MISE_ADDR_CAL) |=> ##1
        (voltage_input_ground_o == $past(sfr_wdata_i[MISE_CAL_VGND_BIT], 2));
  endproperty
  a_volt_ground: assert property (p_volt_ground) else $error("voltage ground does not follow write"); // RQ3

  property p_irq_set;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (|(irq_status_mid_reg & irq_enable_mid_reg)) |=> metering_irq_o;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("enabled flag did not raise interrupt"); // RQ5

  property p_irq_clear;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      !(|(irq_status_low_reg & irq_enable_low_reg) || |(irq_status_mid_reg & irq_enable_mid_reg)
        || |(irq_status_high_reg & irq_enable_high_reg)) |=> !metering_irq_o;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt stayed without enabled flag"); // RQ6

  property p_fault_flag;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      fault_chg |=> irq_status_low_reg[5];
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("fault change flag not set"); // RQ7

  property p_pulse_flag;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      evt_i.pulse_out_two |=> irq_status_mid_reg[MISE_PULSE_TWO_BIT];
  endproperty
  a_pulse_flag: assert property (p_pulse_flag) else $error("pulse flag not set"); // RQ12

  property p_reset_done;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      !rst_seen_reg |=> irq_status_high_reg[MISE_RESET_DONE_BIT];
  endproperty
  a_reset_done: assert property (p_reset_done) else $error("reset-done flag not set"); // RQ15

  property p_sticky;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (irq_status_high_reg[0] && !(sfr_wr_i && sfr_addr_i == MISE_ADDR_ST_HIGH)) |=> irq_status_high_reg[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clearing write"); // RQ24

  property p_sel_force_b;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (calibration_mode_reg[MISE_CAL_SEL_LSB +: 2] == MISE_SEL_FORCE_B) |=> meas_use_b_o;
  endproperty
  a_sel_force_b: assert property (p_sel_force_b) else $error("forced input B not routed"); // RQ1

  // both free codes hand the choice to the tamper logic
  property p_sel_auto;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (calibration_mode_reg[MISE_CAL_SEL_LSB +: 2] != MISE_SEL_FORCE_A
       && calibration_mode_reg[MISE_CAL_SEL_LSB +: 2] != MISE_SEL_FORCE_B) |=> (meas_use_b_o == $past(tamper_sel_b_i));
  endproperty
  a_sel_auto: assert property (p_sel_auto) else $error("automatic input choice not followed"); // RQ1

  property p_summary_read;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (sfr_rd_i && sfr_addr_i == MISE_ADDR_ST_LOW) |=> (sfr_rdata_o[MISE_SUMMARY_BIT] == $past(metering_irq_o));
  endproperty
  a_summary_read: assert property (p_summary_read) else $error("summary bit does not read back"); // RQ5

  // an event always lands, even against a clearing write in the same cycle
  property p_crossing_flag;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      evt_i.crossing |=> irq_status_high_reg[0];
  endproperty
  a_crossing_flag: assert property (p_crossing_flag) else $error("crossing flag not set"); // RQ20 RQ24

  c_irq_raise: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) $rose(metering_irq_o));
  c_irq_drop: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) $fell(metering_irq_o));
  c_force_b: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) $rose(meas_use_b_o));
  c_act_chg: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) act_chg);
  c_summary_read: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    sfr_rd_i && sfr_addr_i == MISE_ADDR_ST_LOW && metering_irq_o);
endmodule

/* test_metering_irq_status_enable.sv */
// self-checking bench of the metering interrupt status/enable block
module test_metering_irq_status_enable
  import mise_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i;
  logic rstn_i;
  logic [7:0] sfr_addr_i;
  logic sfr_wr_i;
  logic [7:0] sfr_wdata_i;
  logic sfr_rd_i;
  logic [7:0] sfr_rdata_o;
  mise_evt_t evt_i;
  mise_sign_t sign_i;
  mise_sign_t sign_dir_i;
  logic tamper_sel_b_i;
  logic meas_use_b_o;
  logic current_input_ground_o;
  logic voltage_input_ground_o;
  logic metering_irq_o;
  logic [7:0] exp_q[$];
  logic rd_taken = 1'b0;
  logic [31:0] seed = 32'h00007FC8;
  int n_errors = 0;
  int checks = 0;

  mise_core_model mise_core_model_i (.ref_clk_i(ref_clk_i), .sfr_addr_o(sfr_addr_i), .sfr_wr_o(sfr_wr_i),
    .sfr_wdata_o(sfr_wdata_i), .sfr_rd_o(sfr_rd_i));
  mise_top mise_top_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .evt_i(evt_i), .sign_i(sign_i),
    .sign_dir_i(sign_dir_i), .tamper_sel_b_i(tamper_sel_b_i), .meas_use_b_o(meas_use_b_o),
    .current_input_ground_o(current_input_ground_o), .voltage_input_ground_o(voltage_input_ground_o),
    .metering_irq_o(metering_irq_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic conclude();
    $display("errors %0d, checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t read got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic compare_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    exp_q.push_back(exp);
    mise_core_model_i.read(addr);
  endtask

  // read data stands from the edge after the strobe, so look at the next falling edge
  always @(posedge ref_clk_i) rd_taken <= sfr_rd_i;
  always @(negedge ref_clk_i) begin
    if (rd_taken === 1'b1) begin
      compare_byte(sfr_rdata_o, exp_q.pop_front());
    end
  end

  // event index k of the packed event struct to {status address, flag bit}
  function automatic logic [10:0] slot(input int k);
    if (k >= 15) return {MISE_ADDR_ST_LOW, (k >= 17) ? 3'h2 : 3'(k - 15)};
    if (k >= 7) return {MISE_ADDR_ST_MID, 3'(k - 7)};
    return {MISE_ADDR_ST_HIGH, (k == 6) ? 3'h7 : 3'(k)};
  endfunction

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    logic [31:0] r;
    logic [7:0] v;
    logic [7:0] a;
    logic [7:0] m;
    logic d;
    rstn_i = 1'b0;
    evt_i = '0;
    sign_i = '0;
    sign_dir_i = '0;
    tamper_sel_b_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i) rstn_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    compare_bit(metering_irq_o, 1'b0, "irq after reset");
    rd_chk(MISE_ADDR_ST_HIGH, 8'h80);
    rd_chk(MISE_ADDR_CAL, MISE_RST_BYTE);
    rd_chk(8'h00, 8'h00);
    for (int s = 0; s < 8; s++) begin
      r = xs();
      v = {2'h0, 2'(s), r[1:0], 2'h0};
      tamper_sel_b_i = r[2];
      mise_core_model_i.write(MISE_ADDR_CAL, v);
      repeat (2) @(negedge ref_clk_i);
      compare_bit(meas_use_b_o, (s % 4 == 1) ? 1'b0 : (s % 4 == 2) ? 1'b1 : r[2], "input b");
      compare_bit(current_input_ground_o, r[0], "current ground");
      compare_bit(voltage_input_ground_o, r[1], "voltage ground");
      rd_chk(MISE_ADDR_CAL, v);
    end
    mise_core_model_i.write(MISE_ADDR_ST_HIGH, 8'h00);
    for (int k = 0; k < $bits(mise_evt_t); k++) begin
      {a, m} = {slot(k), 5'h00};
      m = 8'h01 << m[7:5];
      @(negedge ref_clk_i) evt_i = mise_evt_t'(19'h1 << k);
      @(negedge ref_clk_i) evt_i = '0;
      repeat (2) @(negedge ref_clk_i);
      compare_bit(metering_irq_o, 1'b0, "masked flag");
      rd_chk(a, m);
      mise_core_model_i.write(a - 8'h03, m);
      repeat (2) @(negedge ref_clk_i);
      compare_bit(metering_irq_o, 1'b1, "enabled flag");
      rd_chk(a, (a == MISE_ADDR_ST_LOW) ? (m | (8'h01 << MISE_SUMMARY_BIT)) : m);
      mise_core_model_i.write(a, ~m);
      repeat (2) @(negedge ref_clk_i);
      compare_bit(metering_irq_o, 1'b0, "flag cleared");
      rd_chk(a, 8'h00);
      mise_core_model_i.write(a - 8'h03, 8'h00);
    end
    for (int j = 0; j < 6; j++) begin
      d = j[0];
      @(negedge ref_clk_i) begin
        sign_dir_i = d ? 3'h7 : 3'h0;
        sign_i[j / 2] = ~d;
      end
      repeat (4) @(negedge ref_clk_i);
      mise_core_model_i.write(MISE_ADDR_ST_LOW, 8'h00);
      @(negedge ref_clk_i) sign_i[j / 2] = d;
      repeat (4) @(negedge ref_clk_i);
      rd_chk(MISE_ADDR_ST_LOW, 8'h00);
      @(negedge ref_clk_i) sign_i[j / 2] = ~d;
      repeat (4) @(negedge ref_clk_i);
      rd_chk(MISE_ADDR_ST_LOW, 8'h01 << (3 + j / 2));
    end
    // a hardware reset in mid-run must raise the reset-done flag again and drop the calibration choice
    @(negedge ref_clk_i) rstn_i = 1'b0;
    @(negedge ref_clk_i) rstn_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    rd_chk(MISE_ADDR_ST_HIGH, 8'h80);
    rd_chk(MISE_ADDR_CAL, MISE_RST_BYTE);
    repeat (3) @(negedge ref_clk_i);
    conclude();
  end
endmodule
